/* File: core/pot_pkg.sv */
// Shared constants for the dual potentiometer two-wire link: opcodes, timing and the
// controller's own register map.
// Assumes a single 100 MHz system clock on both ends of the link.
package pot_pkg;
  // Device type code; the value is arbitrary.
  localparam logic [3:0] DEVICE_TYPE       = 4'hA;
  localparam logic [3:0] OP_READ_WIPER     = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER    = 4'hA;
  localparam logic [3:0] OP_READ_STORED    = 4'hB;
  localparam logic [3:0] OP_WRITE_STORED   = 4'hC;
  localparam logic [3:0] OP_XFR_TO_WIPER   = 4'hD;
  localparam logic [3:0] OP_XFR_TO_STORED  = 4'hE;
  localparam logic [3:0] OP_GXFR_TO_WIPER  = 4'h1;
  localparam logic [3:0] OP_GXFR_TO_STORED = 4'h8;
  localparam logic [3:0] OP_STEP           = 4'h2;
  localparam logic [5:0] STORED_RESET      = 6'h00;
  localparam logic [5:0] WIPER_TOP         = 6'h3F;
  localparam int         CLK_PERIOD_NS     = 10;
  localparam int         WRITE_TIME_NS     = 5000000;
  localparam int         WRITE_CYCLES      = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int         LINK_PERIOD_NS    = 160;
  localparam int         QUARTER_CYCLES    = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Controller register offsets.
  localparam logic [2:0] REG_DEV_ADDR      = 3'h0;
  localparam logic [2:0] REG_INSTR         = 3'h1;
  localparam logic [2:0] REG_DATA          = 3'h2;
  localparam logic [2:0] REG_GO            = 3'h3;
  localparam logic [2:0] REG_STATUS        = 3'h4;
  localparam logic [2:0] REG_RDATA         = 3'h5;
  // Transfer kinds written to the go register.
  localparam logic [2:0] KIND_TWO_BYTE     = 3'h0;
  localparam logic [2:0] KIND_WRITE        = 3'h1;
  localparam logic [2:0] KIND_READ         = 3'h2;
  localparam logic [2:0] KIND_STEP         = 3'h3;
  localparam logic [2:0] KIND_POLL         = 3'h4;
endpackage : pot_pkg

/* File: core/two_wire_if.sv */
// Two-wire link between the controller and the potentiometer device.
// Assumes both ends sit on the same system clock; data is open drain, clock push-pull.
`timescale 1ns/1ns
`default_nettype none
interface two_wire_if;
  logic scl;
  logic master_sda_oe;
  logic device_sda_oe;
  logic sda_level;
  // An enable pulls the shared data line low; otherwise the pull-up wins.
  assign sda_level = ~(master_sda_oe | device_sda_oe);
  modport master (output scl, output master_sda_oe, input sda_level);
  modport device (input scl, output device_sda_oe, input sda_level);
endinterface : two_wire_if
`default_nettype wire

/* File: core/pot_device.sv */
// Slave end of the dual potentiometer: address match, instruction decode, stored
// settings, write-cycle timing and tap decoding.
// Assumes a master on two_wire_if that drives the clock at a fraction of clk.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE_01: Ignore traffic until a start is seen.
// RULE_02: Stop ends the transfer.
// RULE_03: Release after eight bits; ninth clock acknowledges.
// RULE_04: Acknowledge address, instruction and data byte.
// RULE_05: Fixed type code; low nibble matches straps.
// RULE_06: Wiper decodes to one of sixty-four taps.
// RULE_07: Stop starts write cycle; address unacknowledged meanwhile.
// RULE_08: Master polls with start and address.
// RULE_09: Opcode, register select, zero bit, pot select.
// RULE_10: Transfers end after the instruction byte.
// RULE_11: Stored-to-wiper transfer is a volatile load.
// RULE_12: Wiper-to-stored transfer starts nonvolatile write.
// RULE_13: Global transfers act on both pots.
// RULE_14: Reads and writes use three bytes.
// RULE_15: Each clock high steps wiper by data level.
// RULE_16: Opcodes 1001 and 1010 access the wiper.
// RULE_17: Opcodes 1011 and 1100 access stored settings.
// RULE_18: Opcodes 1101 and 1110 transfer one pot.
// RULE_19: Opcodes 0001 and 1000 transfer both pots.
// RULE_20: Opcode 0010 enables stepping of selected wiper.
// RULE_21: Write protect low blocks nonvolatile writes.
// RULE_22: Power-up loads wiper from stored register zero.
// RULE_23: Stepping saturates at 0 and 63.
// RULE_24: Undefined opcodes are ignored.
module pot_device #(
  parameter int WRITE_TIME_CYCLES = pot_pkg::WRITE_CYCLES
) (
  // System.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link.
  two_wire_if.device       bus,
  // Straps and protection.
  input  wire logic [3:0]  address_strap_inputs,
  input  wire logic        write_protect_n,
  // Tap switches and write state.
  output var  logic [63:0] tap_enable_0,
  output var  logic [63:0] tap_enable_1,
  output var  logic        write_busy
);
  import pot_pkg::*;

  if (WRITE_TIME_CYCLES < 1) begin : g_check
    $error("WRITE_TIME_CYCLES must be at least one");
  end

  localparam int TW = $clog2(WRITE_TIME_CYCLES + 1);

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_ADDR  = 3'b001,
    D_INSTR = 3'b011,
    D_RX    = 3'b010,
    D_TX    = 3'b110,
    D_STEP  = 3'b111,
    D_SKIP  = 3'b101
  } dev_state_e;

  function automatic logic instr_valid(input logic [7:0] b);
    logic zero_sel;
    zero_sel = (b[3:2] == 2'b00);
    if (b[1]) begin
      return 1'b0; // RULE_09
    end
    unique case (b[7:4])
      OP_READ_WIPER, OP_WRITE_WIPER, OP_STEP: return zero_sel; // RULE_16 RULE_20
      OP_READ_STORED, OP_WRITE_STORED: return 1'b1; // RULE_17
      OP_XFR_TO_WIPER, OP_XFR_TO_STORED: return 1'b1; // RULE_18
      OP_GXFR_TO_WIPER, OP_GXFR_TO_STORED: return ~b[0]; // RULE_19
      default: return 1'b0; // RULE_24
    endcase
  endfunction : instr_valid

  function automatic logic [5:0] step_wiper(input logic [5:0] v, input logic up);
    if (up) begin
      return (v == WIPER_TOP) ? v : v + 6'h01; // RULE_23
    end
    return (v == 6'h00) ? v : v - 6'h01; // RULE_23
  endfunction : step_wiper

  // Pin synchronisers; the second stage and its delayed copy feed all edge logic.
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, wp_m, wp_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_q} <= 3'b111;
      {sda_m, sda_s, sda_q} <= 3'b111;
      {wp_m, wp_s}          <= 2'b11;
    end else begin
      {scl_m, scl_s, scl_q} <= {bus.scl, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {bus.sda_level, sda_m, sda_s};
      {wp_m, wp_s}          <= {write_protect_n, wp_m};
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s; // RULE_01
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s; // RULE_02

  dev_state_e     state, next_state, after, next_after;
  logic [3:0]     bit_cnt, next_bit_cnt;
  logic [7:0]     shreg, next_shreg, txbyte, next_txbyte, instr, next_instr;
  logic           sda_oe, next_sda_oe, recalled, next_recalled;
  logic [5:0]     wiper_position_register [2];
  logic [5:0]     next_wcr [2];
  logic [5:0]     dr [2][4];
  logic [5:0]     next_dr [2][4];
  logic           pend, next_pend, pend_global, next_pend_global, pend_pot, next_pend_pot;
  logic [1:0]     pend_reg, next_pend_reg;
  logic [5:0]     pend_data [2];
  logic [5:0]     next_pend_data [2];
  logic           busy, next_busy;
  logic [TW-1:0]  timer, next_timer;
  logic [63:0]    next_tap_0, next_tap_1;

  logic [3:0] op;
  logic       pot;
  logic [1:0] rsel;
  assign op   = shreg[7:4];
  assign rsel = shreg[3:2];
  assign pot  = shreg[0];

  always_comb begin
    next_state       = state;
    next_after       = after;
    next_bit_cnt     = bit_cnt;
    next_shreg       = shreg;
    next_txbyte      = txbyte;
    next_instr       = instr;
    next_sda_oe      = sda_oe;
    next_recalled    = 1'b1;
    next_wcr         = wiper_position_register;
    next_dr          = dr;
    next_pend        = pend;
    next_pend_global = pend_global;
    next_pend_pot    = pend_pot;
    next_pend_reg    = pend_reg;
    next_pend_data   = pend_data;
    next_busy        = busy;
    next_timer       = timer;
    if (!recalled) begin
      next_wcr[0] = dr[0][0]; // RULE_22
      next_wcr[1] = dr[1][0]; // RULE_22
    end
    if (busy) begin
      next_timer = timer - TW'(1);
      if (timer == '0) begin
        next_busy = 1'b0;
        next_pend = 1'b0;
        for (int p = 0; p < 2; p++) begin
          if (pend_global || pend_pot == p[0]) begin
            next_dr[p][pend_reg] = pend_data[p]; // RULE_12 RULE_13
          end
        end
      end
    end
    if (start_det) begin
      next_state   = D_ADDR; // RULE_01
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_det) begin
      next_state  = D_IDLE; // RULE_02
      next_sda_oe = 1'b0;
      if (pend && !busy) begin
        if (wp_s) begin
          next_busy  = 1'b1; // RULE_07
          next_timer = TW'(WRITE_TIME_CYCLES - 1);
        end else begin
          next_pend = 1'b0; // RULE_21
        end
      end
    end else if (state == D_STEP) begin
      // The direction is taken at the rise and applied at the fall, so the
      // clock rise that opens a stop condition never counts as a step.
      if (scl_rise) begin
        next_shreg = {shreg[6:0], sda_s}; // RULE_15
      end else if (scl_fall) begin
        next_wcr[instr[0]] = step_wiper(wiper_position_register[instr[0]], shreg[0]); // RULE_15
      end
    end else if (state != D_IDLE && state != D_SKIP) begin
      if (scl_rise) begin
        next_shreg   = {shreg[6:0], sda_s};
        next_bit_cnt = bit_cnt + 4'h1;
      end else if (scl_fall && bit_cnt == 4'h8) begin
        next_sda_oe = 1'b0; // RULE_03
        next_after  = D_SKIP;
        unique case (state)
          D_ADDR: begin
            if (shreg[7:4] == DEVICE_TYPE && shreg[3:0] == address_strap_inputs
                && !busy) begin // RULE_05 RULE_07
              next_sda_oe = 1'b1; // RULE_04
              next_after  = D_INSTR;
            end
          end
          D_INSTR: begin
            if (instr_valid(shreg)) begin
              next_sda_oe = 1'b1; // RULE_04
              next_instr  = shreg;
              unique case (op)
                OP_READ_WIPER: begin
                  next_txbyte = {2'b00, wiper_position_register[pot]}; // RULE_16 RULE_14
                  next_after  = D_TX;
                end
                OP_READ_STORED: begin
                  next_txbyte = {2'b00, dr[pot][rsel]}; // RULE_17 RULE_14
                  next_after  = D_TX;
                end
                OP_WRITE_WIPER, OP_WRITE_STORED: next_after = D_RX; // RULE_14
                OP_STEP: next_after = D_STEP; // RULE_20
                OP_XFR_TO_WIPER: next_wcr[pot] = dr[pot][rsel]; // RULE_10 RULE_11 RULE_18
                OP_GXFR_TO_WIPER: begin
                  next_wcr[0] = dr[0][rsel]; // RULE_11 RULE_13 RULE_19
                  next_wcr[1] = dr[1][rsel];
                end
                default: begin
                  // Both remaining codes are wiper-to-stored transfers.
                  next_pend         = !busy; // RULE_10 RULE_12
                  next_pend_global  = (op == OP_GXFR_TO_STORED); // RULE_13 RULE_19
                  next_pend_pot     = pot; // RULE_18
                  next_pend_reg     = rsel;
                  next_pend_data[0] = wiper_position_register[0];
                  next_pend_data[1] = wiper_position_register[1];
                end
              endcase
            end
          end
          D_RX: begin
            next_sda_oe = 1'b1; // RULE_04
            if (instr[7:4] == OP_WRITE_WIPER) begin
              next_wcr[instr[0]] = shreg[5:0]; // RULE_16
            end else begin
              next_pend                 = 1'b1; // RULE_17
              next_pend_global          = 1'b0;
              next_pend_pot             = instr[0];
              next_pend_reg             = instr[3:2];
              next_pend_data[instr[0]]  = shreg[5:0];
            end
          end
          default: next_sda_oe = 1'b0; // RULE_03
        endcase
      end else if (scl_fall && bit_cnt == 4'h9) begin
        next_bit_cnt = 4'h0;
        next_state   = after;
        next_sda_oe  = (after == D_TX) & ~txbyte[7];
        next_txbyte  = {txbyte[6:0], 1'b0};
      end else if (scl_fall && state == D_TX) begin
        next_sda_oe = ~txbyte[7];
        next_txbyte = {txbyte[6:0], 1'b0};
      end
    end
    next_tap_0 = 64'h1 << wiper_position_register[0]; // RULE_06
    next_tap_1 = 64'h1 << wiper_position_register[1]; // RULE_06
  end

  // The tap registers add one clock of wiper response after any wiper change.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= D_IDLE;
      after        <= D_SKIP;
      bit_cnt      <= 4'h0;
      shreg        <= 8'h00;
      txbyte       <= 8'h00;
      instr        <= 8'h00;
      sda_oe       <= 1'b0;
      recalled     <= 1'b0;
      pend         <= 1'b0;
      pend_global  <= 1'b0;
      pend_pot     <= 1'b0;
      pend_reg     <= 2'b00;
      busy         <= 1'b0;
      timer        <= '0;
      tap_enable_0 <= 64'h1 << STORED_RESET;
      tap_enable_1 <= 64'h1 << STORED_RESET;
      for (int p = 0; p < 2; p++) begin
        wiper_position_register[p]       <= STORED_RESET;
        pend_data[p] <= 6'h00;
        for (int r = 0; r < 4; r++) begin
          dr[p][r] <= STORED_RESET;
        end
      end
    end else begin
      state        <= next_state;
      after        <= next_after;
      bit_cnt      <= next_bit_cnt;
      shreg        <= next_shreg;
      txbyte       <= next_txbyte;
      instr        <= next_instr;
      sda_oe       <= next_sda_oe;
      recalled     <= next_recalled;
      wiper_position_register          <= next_wcr;
      dr           <= next_dr;
      pend         <= next_pend;
      pend_global  <= next_pend_global;
      pend_pot     <= next_pend_pot;
      pend_reg     <= next_pend_reg;
      pend_data    <= next_pend_data;
      busy         <= next_busy;
      timer        <= next_timer;
      tap_enable_0 <= next_tap_0;
      tap_enable_1 <= next_tap_1;
    end
  end

  assign bus.device_sda_oe = sda_oe;
  assign write_busy        = busy;
endmodule : pot_device
`default_nettype wire

/* File: core/pot_master.sv */
// Controller end of the potentiometer link: a register port that launches one
// framed transfer at a time and reports acknowledge and read data.
// Assumes the device end shares clk and answers on the open-drain data line.
`timescale 1ns/1ns
`default_nettype none
module pot_master #(
  parameter int QUARTER = pot_pkg::QUARTER_CYCLES
) (
  // System.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link.
  two_wire_if.master      bus,
  // Register port.
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata
);
  import pot_pkg::*;

  if (QUARTER < 3) begin : g_check
    $error("QUARTER must be at least three clocks for the data synchroniser");
  end

  typedef enum logic [1:0] {M_IDLE = 2'b00, M_START = 2'b01, M_BITS = 2'b11, M_STOP = 2'b10}
    mst_state_e;

  logic sda_m, sda_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {sda_m, sda_s} <= 2'b11;
    end else begin
      {sda_m, sda_s} <= {bus.sda_level, sda_m};
    end
  end

  mst_state_e state, next_state;
  logic [7:0] qcnt, next_qcnt, instr, next_instr, data, next_data, rbuf, next_rbuf, next_rdata;
  logic [3:0] dev_addr, next_dev_addr, bit_idx, next_bit_idx;
  logic [2:0] kind, next_kind;
  logic [1:0] phase, next_phase, byte_idx, next_byte_idx;
  logic [5:0] steps, next_steps;
  logic       scl, next_scl, oe, next_oe, nack, next_nack;
  logic       tick, reading, stepping, last_byte;
  logic [7:0] txb;

  assign tick      = (qcnt == 8'(QUARTER - 1));
  assign reading   = (kind == KIND_READ) && (byte_idx == 2'd2);
  assign stepping  = (kind == KIND_STEP) && (byte_idx == 2'd2);
  // A stepping frame is closed by its step counter, not by a byte count.
  assign last_byte = (kind == KIND_POLL) ? (byte_idx == 2'd0)
                   : (kind == KIND_WRITE || kind == KIND_READ) ? (byte_idx == 2'd2)
                   : (kind == KIND_STEP) ? 1'b0
                   : (byte_idx == 2'd1);
  assign txb = (byte_idx == 2'd0) ? {DEVICE_TYPE, dev_addr}
             : (byte_idx == 2'd1) ? instr : data;

  always_comb begin
    next_state    = state;
    next_qcnt     = (state == M_IDLE || tick) ? 8'h00 : qcnt + 8'h01;
    next_phase    = (state != M_IDLE && tick) ? phase + 2'd1 : phase;
    next_instr    = instr;
    next_data     = data;
    next_dev_addr = dev_addr;
    next_kind     = kind;
    next_rbuf     = rbuf;
    next_bit_idx  = bit_idx;
    next_byte_idx = byte_idx;
    next_steps    = steps;
    next_scl      = scl;
    next_oe       = oe;
    next_nack     = nack;
    next_rdata    = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_DEV_ADDR: next_rdata = {4'h0, dev_addr};
        REG_INSTR:    next_rdata = instr;
        REG_DATA:     next_rdata = data;
        REG_STATUS:   next_rdata = {6'h00, nack, state != M_IDLE};
        REG_RDATA:    next_rdata = rbuf;
        default:      next_rdata = 8'h00;
      endcase
    end
    if (reg_wr && state == M_IDLE) begin
      unique case (reg_addr)
        REG_DEV_ADDR: next_dev_addr = reg_wdata[3:0];
        REG_INSTR:    next_instr = reg_wdata;
        REG_DATA:     next_data = reg_wdata;
        REG_GO: begin
          next_kind  = reg_wdata[2:0];
          next_state = M_START;
          next_phase = 2'd0;
          next_nack  = 1'b0;
        end
        default: ;
      endcase
    end
    if (tick) begin
      unique case (state)
        M_START: begin
          unique case (phase)
            2'd0: begin
              next_scl = 1'b1;
              next_oe  = 1'b0;
            end
            2'd1: next_oe = 1'b1; // RULE_01
            2'd2: next_scl = 1'b0;
            default: begin
              next_state    = M_BITS;
              next_byte_idx = 2'd0;
              next_bit_idx  = 4'h0;
              next_steps    = data[5:0];
            end
          endcase
        end
        M_BITS: begin
          unique case (phase)
            2'd0: begin
              if (stepping) begin
                next_oe = ~data[7]; // RULE_15
              end else begin
                next_oe = (bit_idx < 4'h8) && !reading && !txb[3'(4'h7 - bit_idx)]; // RULE_03
              end
            end
            2'd1: next_scl = 1'b1;
            2'd2: begin
              if (!stepping && bit_idx < 4'h8) begin
                next_rbuf = reading ? {rbuf[6:0], sda_s} : rbuf;
              end else if (!stepping && !reading && sda_s) begin
                next_nack = 1'b1; // RULE_08
              end
            end
            default: begin
              next_scl = 1'b0;
              if (stepping) begin
                next_steps = steps - 6'h01;
                next_state = (steps == 6'h01) ? M_STOP : M_BITS;
              end else if (bit_idx == 4'h8) begin
                next_bit_idx  = 4'h0;
                next_byte_idx = byte_idx + 2'd1;
                if (nack || last_byte || (kind == KIND_STEP && data[5:0] == 6'h00)) begin
                  next_state = M_STOP; // RULE_14
                end
              end else begin
                next_bit_idx = bit_idx + 4'h1;
              end
            end
          endcase
        end
        M_STOP: begin
          unique case (phase)
            2'd0: next_oe = 1'b1;
            2'd1: next_scl = 1'b1;
            2'd2: next_oe = 1'b0; // RULE_02
            default: next_state = M_IDLE;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= M_IDLE;
      qcnt      <= 8'h00;
      phase     <= 2'd0;
      instr     <= 8'h00;
      data      <= 8'h00;
      dev_addr  <= 4'h0;
      kind      <= KIND_TWO_BYTE;
      rbuf      <= 8'h00;
      bit_idx   <= 4'h0;
      byte_idx  <= 2'd0;
      steps     <= 6'h00;
      scl       <= 1'b1;
      oe        <= 1'b0;
      nack      <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      state     <= next_state;
      qcnt      <= next_qcnt;
      phase     <= next_phase;
      instr     <= next_instr;
      data      <= next_data;
      dev_addr  <= next_dev_addr;
      kind      <= next_kind;
      rbuf      <= next_rbuf;
      bit_idx   <= next_bit_idx;
      byte_idx  <= next_byte_idx;
      steps     <= next_steps;
      scl       <= next_scl;
      oe        <= next_oe;
      nack      <= next_nack;
      reg_rdata <= next_rdata;
    end
  end

  assign bus.scl           = scl;
  assign bus.master_sda_oe = oe;
endmodule : pot_master
`default_nettype wire

/* File: tb/pot_link_sva.sv */
// Checker for the two-wire link between the controller and the potentiometer device.
// Assumes four clocks a quarter bit, so one link bit spans sixteen clocks.
`timescale 1ns/1ns
`default_nettype none
module pot_link_sva (
  // System.
  input wire logic clk,
  input wire logic rst_n,
  // Link.
  input wire logic scl,
  input wire logic master_sda_oe,
  input wire logic device_sda_oe,
  input wire logic sda_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dev_hold; scl && $past(scl) |-> $stable(device_sda_oe); endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device data moved in clock high");
  property p_start; scl && $past(scl) && $fell(sda_level) |-> master_sda_oe && !device_sda_oe;
  endproperty
  a_start: assert property (p_start) else $error("start not made by the controller");
  property p_stop; scl && $past(scl) && $rose(sda_level) |=> !device_sda_oe [*8]; endproperty
  a_stop: assert property (p_stop) else $error("device drove data after stop");
  property p_high; $rose(scl) |-> scl [*8]; endproperty
  a_high: assert property (p_high) else $error("clock high pulse too short");
  property p_low; $fell(scl) |-> ##[1:32] $rose(scl); endproperty
  a_low: assert property (p_low) else $error("clock held low too long");
  property p_release; $rose(device_sda_oe) |-> ##[1:200] $fell(device_sda_oe); endproperty
  a_release: assert property (p_release) else $error("device never released data");
  property p_drive_low; $rose(device_sda_oe) |-> !scl && !$past(scl); endproperty
  a_drive_low: assert property (p_drive_low) else $error("device drove in clock high");
  // The device resynchronises the clock, so it cannot answer in the cycle after a fall.
  property p_fall_wait; $fell(scl) |=> $stable(device_sda_oe); endproperty
  a_fall_wait: assert property (p_fall_wait) else $error("device answered too early");
endmodule : pot_link_sva
`default_nettype wire

/* File: tb/dual_pot_serial_command_slave_tb_top.sv */
// Bench for the potentiometer link: controller and device joined across two_wire_if.
// Assumes a shortened device write time so that acknowledge polling stays brief.
`timescale 1ns/1ns
`default_nettype none
module dual_pot_serial_command_slave_tb_top;
  import pot_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        write_protect_n;
  logic [63:0] tap_enable_0;
  logic [63:0] tap_enable_1;
  logic        write_busy;
  logic [7:0]  st;
  int          errors;
  int          checks_done;
  two_wire_if bus ();
  pot_master pot_master_i (.clk(clk), .rst_n(rst_n), .bus(bus), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // A write time longer than one poll frame makes the first poll meet a busy device.
  pot_device #(.WRITE_TIME_CYCLES(400)) pot_device_i (.clk(clk), .rst_n(rst_n), .bus(bus),
    .address_strap_inputs(4'h5), .write_protect_n(write_protect_n),
    .tap_enable_0(tap_enable_0), .tap_enable_1(tap_enable_1), .write_busy(write_busy));
  pot_link_sva pot_link_sva_i (.clk(clk), .rst_n(rst_n), .scl(bus.scl),
    .master_sda_oe(bus.master_sda_oe), .device_sda_oe(bus.device_sda_oe),
    .sda_level(bus.sda_level));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic go(input logic [7:0] ins, input logic [7:0] dat, input logic [2:0] kind);
    wr(REG_INSTR, ins);
    wr(REG_DATA, dat);
    wr(REG_GO, {5'h00, kind});
    st = 8'h01;
    for (int i = 0; i < 3000 && st[0] !== 1'b0; i++) rd(REG_STATUS, st);
    if (st[0] !== 1'b0) begin
      errors++;
      $display("BAD %0t transfer hung", $time);
      wrap_up();
    end
  endtask : go
  task automatic rdchk(input logic [7:0] ins, input logic [5:0] v);
    logic [7:0] d;
    go(ins, 8'h00, KIND_READ);
    rd(REG_RDATA, d);
    chk(d, {2'b00, v}, "read value");
  endtask : rdchk
  task automatic taps(input logic [5:0] w0, input logic [5:0] w1);
    chk(tap_enable_0, 64'h1 << w0, "tap of pot 0");
    chk(tap_enable_1, 64'h1 << w1, "tap of pot 1");
  endtask : taps
  task automatic poll();
    go(8'h00, 8'h00, KIND_POLL);
    chk(st[1], 1'b1, "poll acknowledged while busy");
    for (int i = 0; i < 10 && st[1] !== 1'b0; i++) go(8'h00, 8'h00, KIND_POLL);
    chk(st[1], 1'b0, "poll never acknowledged");
  endtask : poll
  task automatic t_refuse();
    logic [3:0] bad [7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
    wr(REG_DEV_ADDR, 8'h06);
    go(8'h90, 8'h00, KIND_READ);
    chk(st[1], 1'b1, "foreign address acknowledged");
    wr(REG_DEV_ADDR, 8'h05);
    for (int k = 0; k < 7; k++) begin
      go({bad[k], 4'h0}, 8'h11, KIND_WRITE);
      chk(st[1], 1'b1, "undefined opcode acknowledged");
    end
    go(8'hA2, 8'h11, KIND_WRITE);
    chk(st[1], 1'b1, "bit one set acknowledged");
    rdchk(8'h90, 6'h3F);
  endtask : t_refuse
  task automatic t_stored();
    go(8'hC4, 8'h2A, KIND_WRITE);
    chk(write_busy, 1'b1, "no write cycle after stop");
    poll();
    rdchk(8'hB4, 6'h2A);
    go(8'hD4, 8'h00, KIND_TWO_BYTE);
    taps(6'h2A, 6'h05);
    go(8'hED, 8'h00, KIND_TWO_BYTE);
    poll();
    rdchk(8'hBD, 6'h05);
  endtask : t_stored
  task automatic t_global();
    go(8'hA1, 8'h09, KIND_WRITE);
    go(8'h88, 8'h00, KIND_TWO_BYTE);
    poll();
    rdchk(8'hB9, 6'h09);
    go(8'hA0, 8'h00, KIND_WRITE);
    go(8'hA1, 8'h00, KIND_WRITE);
    go(8'h18, 8'h00, KIND_TWO_BYTE);
    taps(6'h2A, 6'h09);
  endtask : t_global
  task automatic t_protect();
    @(posedge clk);
    write_protect_n <= 1'b0;
    go(8'hCC, 8'h3F, KIND_WRITE);
    chk(write_busy, 1'b0, "protected write started");
    rdchk(8'hBC, 6'h00);
    @(posedge clk);
    write_protect_n <= 1'b1;
  endtask : t_protect
  task automatic t_step();
    go(8'h20, 8'hBF, KIND_STEP);
    taps(6'h3F, 6'h09);
    go(8'h20, 8'h03, KIND_STEP);
    go(8'h21, 8'h14, KIND_STEP);
    taps(6'h3C, 6'h00);
  endtask : t_step
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, write_protect_n} = '0;
    write_protect_n = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(REG_DEV_ADDR, 8'h05);
    chk(write_busy, 1'b0, "busy after reset");
    taps(6'h00, 6'h00);
    go(8'hA0, 8'h3F, KIND_WRITE);
    go(8'hA1, 8'h05, KIND_WRITE);
    rdchk(8'h91, 6'h05);
    taps(6'h3F, 6'h05);
    t_refuse();
    t_stored();
    t_global();
    t_protect();
    t_step();
    wrap_up();
  end
endmodule : dual_pot_serial_command_slave_tb_top
`default_nettype wire
